// ### shared/i2scf_pkg.sv
// Constants, register map and helpers for the I2S channel-0 control block.
// Assumes a 125 MHz APB clock and a 12-bit byte address inside the unit.
package i2scf_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] LEFT_HOLD_OFS     = 12'h020;
  localparam logic [11:0] RIGHT_HOLD_OFS    = 12'h024;
  localparam logic [11:0] RX_CONFIG_OFS     = 12'h030;
  localparam logic [11:0] TX_CONFIG_OFS     = 12'h034;
  localparam logic [11:0] IRQ_STATUS_OFS    = 12'h038;
  localparam logic [11:0] IRQ_MASK_OFS      = 12'h03C;
  localparam logic [11:0] RX_OVR_CLEAR_OFS  = 12'h040;
  localparam logic [11:0] TX_OVR_CLEAR_OFS  = 12'h044;
  localparam logic [11:0] RX_TRIGGER_OFS    = 12'h048;
  localparam logic [11:0] TX_TRIGGER_OFS    = 12'h04C;
  localparam logic [11:0] RX_FLUSH_OFS      = 12'h050;
  localparam logic [11:0] TX_FLUSH_OFS      = 12'h054;
  localparam logic [11:0] UNIT_CTRL_OFS     = 12'h060;
  localparam logic [11:0] RX_DMA_OFS        = 12'h1C0;
  localparam logic [11:0] RX_DMA_PTR_RST_OFS = 12'h1C4;
  localparam logic [11:0] TX_DMA_OFS        = 12'h1C8;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          ST_TX_OVR    = 5;
  localparam int          ST_TX_EMPTY  = 4;
  localparam int          ST_RX_OVR    = 1;
  localparam int          ST_RX_READY  = 0;
  localparam int          CTRL_RX_EN   = 0;
  localparam int          CTRL_TX_EN   = 1;
  localparam logic [5:0]  IRQ_BITS     = 6'h33;
  localparam logic [5:0]  MASK_RESET   = 6'h33;
  localparam logic [5:0]  STATUS_RESET = 6'h10;
  localparam logic [2:0]  WORD_LENGTH_SEL_RESET   = 3'h2;
  localparam logic [3:0]  TRIG_RESET   = 4'h3;

  // ----------------------------------------------------------------
  // FIFO shape and serial timing
  // ----------------------------------------------------------------
  localparam int          FIFO_DEPTH    = 8;
  localparam int          FIFO_AW       = 3;
  localparam logic [3:0]  FIFO_FULL_LVL = 4'h8;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          SCLK_HALF_NS  = 40;
  localparam logic [7:0]  SCLK_HALF_CYC = 8'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Word length codes; ignore-length takes the whole 32-bit slot
  function automatic logic [5:0] i2scf_word_bits(input logic [2:0] sel);
    case (sel)
      3'h1:    i2scf_word_bits = 6'h0C;
      3'h2:    i2scf_word_bits = 6'h10;
      3'h3:    i2scf_word_bits = 6'h14;
      3'h4:    i2scf_word_bits = 6'h18;
      default: i2scf_word_bits = 6'h20;
    endcase
  endfunction : i2scf_word_bits

endpackage : i2scf_pkg

// ### shared/i2scf_fifo_if.sv
// Link between the channel control logic and one sample-pair FIFO.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ns
interface i2scf_fifo_if;
  logic        push;
  logic        pop;
  logic        flush;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        full;
  logic        empty;
  logic [3:0]  level;

  modport owner (output push, pop, flush, wdata, input rdata, full, empty, level);
  modport store (input push, pop, flush, wdata, output rdata, full, empty, level);
endinterface : i2scf_fifo_if

// ### rtl/i2scf_fifo.sv
// Sample-pair FIFO, one entry holds {right, left}.
// Assumes the owner never relies on a push or pop that it sees refused.
`timescale 1ns/1ns
module i2scf_fifo (
  input  wire logic   pclk,
  input  wire logic   presetn,
  i2scf_fifo_if.store fifo
);

  typedef struct packed {
    logic [i2scf_pkg::FIFO_DEPTH-1:0][31:0] mem;
    logic [i2scf_pkg::FIFO_AW-1:0]          wr;
    logic [i2scf_pkg::FIFO_AW-1:0]          rd;
    logic [3:0]                             count;
  } i2scf_fifo_state_t;

  i2scf_fifo_state_t st;
  i2scf_fifo_state_t next_st;
  logic              do_push;
  logic              do_pop;

  // ----------------------------------------------------------------
  // Pointer and count update; flush beats both push and pop
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    do_push = fifo.push && (st.count != i2scf_pkg::FIFO_FULL_LVL);
    do_pop  = fifo.pop && (st.count != 4'h0);
    if (fifo.flush) begin
      next_st.wr    = '0;
      next_st.rd    = '0;
      next_st.count = 4'h0;
    end else begin
      if (do_push) begin
        next_st.mem[st.wr] = fifo.wdata;
        next_st.wr         = st.wr + 3'h1;
      end
      if (do_pop) begin
        next_st.rd = st.rd + 3'h1;
      end
      next_st.count = st.count + {3'h0, do_push} - {3'h0, do_pop};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Head word is visible without a pop, so reads may peek
  assign fifo.rdata = st.mem[st.rd];
  assign fifo.full  = (st.count == i2scf_pkg::FIFO_FULL_LVL);
  assign fifo.empty = (st.count == 4'h0);
  assign fifo.level = st.count;

endmodule : i2scf_fifo

// ### rtl/i2scf_channel_ctrl.sv
// I2S channel-0 control: APB registers, FIFOs, serial engine.
// Assumes an APB master on pclk and an I2S peer on the sclk/ws/sd pins.
`timescale 1ns/1ns
module i2scf_channel_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        peripheral_role_select,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  input  wire logic        ws_in,
  output logic             ws_out,
  output logic             ws_oe,
  input  wire logic        sd_in,
  output logic             sd_out,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  rx_word_length_sel;
    logic [2:0]  tx_word_length_sel;
    logic [5:0]  mask;
    logic [3:0]  rx_trig;
    logic [3:0]  tx_trig;
    logic        rx_en;
    logic        tx_en;
    logic        rx_ovr;
    logic        tx_ovr;
    logic [5:0]  status;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        rx_dma_right;
    logic        tx_dma_right;
    logic [15:0] tx_left_hold;
    logic [2:0]  sclk_s;
    logic [1:0]  ws_s;
    logic [1:0]  sd_s;
    logic        master;
    logic [7:0]  div;
    logic        sclk_o;
    logic [5:0]  bitcnt;
    logic        ws_o;
    logic        ws_rx_last;
    logic [31:0] rx_sh;
    logic [15:0] rx_left;
    logic        ws_tx_last;
    logic [31:0] tx_sh;
    logic [15:0] tx_right_pend;
    logic        sd_o;
  } i2scf_state_t;

  i2scf_state_t st;
  i2scf_state_t next_st;

  i2scf_fifo_if rxf ();
  i2scf_fifo_if txf ();

  logic        tick;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        ws_now;
  logic        setup;
  logic        access;
  logic        hit;
  logic [5:0]  rx_len;
  logic [5:0]  tx_len;
  logic [31:0] rx_word;
  logic [31:0] tx_word;
  logic [15:0] tx_sample;

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  i2scf_fifo u_rx_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .fifo    (rxf.store)
  );

  i2scf_fifo u_tx_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .fifo    (txf.store)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st   = st;
    rxf.push  = 1'b0;
    rxf.pop   = 1'b0;
    rxf.flush = 1'b0;
    rxf.wdata = 32'h0;
    txf.push  = 1'b0;
    txf.pop   = 1'b0;
    txf.flush = 1'b0;
    txf.wdata = 32'h0;
    hit       = 1'b0;
    tick      = 1'b0;
    rx_len    = i2scf_pkg::i2scf_word_bits(st.rx_word_length_sel);
    tx_len    = i2scf_pkg::i2scf_word_bits(st.tx_word_length_sel);
    rx_word   = 32'h0;
    tx_word   = 32'h0;
    tx_sample = 16'h0;
    setup     = psel && !penable;
    access    = psel && penable && st.pready;

    // Pin synchronisers; first stage only feeds the second
    next_st.sclk_s = {st.sclk_s[1:0], sclk_in};
    next_st.ws_s   = {st.ws_s[0], ws_in};
    next_st.sd_s   = {st.sd_s[0], sd_in};
    next_st.master = peripheral_role_select;

    // Master clock generator, idle unless this end owns the link and rx or tx is enabled
    if (st.master && (st.rx_en || st.tx_en)) begin
      if (st.div == 8'h0) begin
        tick           = 1'b1;
        next_st.div    = i2scf_pkg::SCLK_HALF_CYC - 8'h1;
        next_st.sclk_o = !st.sclk_o;
        if (st.sclk_o) begin
          next_st.bitcnt = st.bitcnt + 6'h01;
          next_st.ws_o   = next_st.bitcnt[5];   // 32 bit slots per side
        end
      end else begin
        next_st.div = st.div - 8'h1;
      end
    end else begin
      next_st.div    = 8'h0;
      next_st.sclk_o = 1'b0;
      next_st.bitcnt = 6'h00;
      next_st.ws_o   = 1'b0;
    end

    // Edges from whichever engine is selected
    if (st.master) begin
      sclk_rise = tick && !st.sclk_o;
      sclk_fall = tick && st.sclk_o;
      ws_now    = st.ws_o;
    end else begin
      sclk_rise = st.sclk_s[1] && !st.sclk_s[2];
      sclk_fall = !st.sclk_s[1] && st.sclk_s[2];
      ws_now    = st.ws_s[1];
    end

    // APB setup: decode and capture read data one cycle ahead
    // Error answer stands only beside its pready pulse
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    if (setup) begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0;
      hit            = 1'b1;
      case (paddr)
        i2scf_pkg::LEFT_HOLD_OFS:      next_st.prdata = {16'h0, rxf.rdata[15:0]};
        i2scf_pkg::RIGHT_HOLD_OFS:     next_st.prdata = {16'h0, rxf.rdata[31:16]};
        i2scf_pkg::RX_CONFIG_OFS:      next_st.prdata = {29'h0, st.rx_word_length_sel};
        i2scf_pkg::TX_CONFIG_OFS:      next_st.prdata = {29'h0, st.tx_word_length_sel};
        i2scf_pkg::IRQ_STATUS_OFS:     next_st.prdata = {26'h0, st.status};
        i2scf_pkg::IRQ_MASK_OFS:       next_st.prdata = {26'h0, st.mask};
        i2scf_pkg::RX_OVR_CLEAR_OFS:   next_st.prdata = {31'h0, st.rx_ovr};
        i2scf_pkg::TX_OVR_CLEAR_OFS:   next_st.prdata = {31'h0, st.tx_ovr};
        i2scf_pkg::RX_TRIGGER_OFS:     next_st.prdata = {28'h0, st.rx_trig};
        i2scf_pkg::TX_TRIGGER_OFS:     next_st.prdata = {28'h0, st.tx_trig};
        i2scf_pkg::UNIT_CTRL_OFS:      next_st.prdata = {30'h0, st.tx_en, st.rx_en};
        i2scf_pkg::RX_DMA_OFS:         next_st.prdata = st.rx_dma_right ?
                                                        {16'h0, rxf.rdata[31:16]} :
                                                        {16'h0, rxf.rdata[15:0]};
        i2scf_pkg::RX_FLUSH_OFS,
        i2scf_pkg::TX_FLUSH_OFS,
        i2scf_pkg::RX_DMA_PTR_RST_OFS,
        i2scf_pkg::TX_DMA_OFS:         next_st.prdata = 32'h0;   // Write-only ports
        default:                       hit = 1'b0;
      endcase
      next_st.pslverr = !hit;   // Unmapped address answers with an error
    end

    // APB access: writes and read side effects on the completing edge
    if (access && pwrite) begin
      case (paddr)
        i2scf_pkg::RX_CONFIG_OFS:  next_st.rx_word_length_sel = pwdata[2:0];
        i2scf_pkg::TX_CONFIG_OFS:  next_st.tx_word_length_sel = pwdata[2:0];
        i2scf_pkg::IRQ_MASK_OFS:   next_st.mask = pwdata[5:0] & i2scf_pkg::IRQ_BITS;
        i2scf_pkg::RX_TRIGGER_OFS: next_st.rx_trig = pwdata[3:0];
        i2scf_pkg::TX_TRIGGER_OFS: next_st.tx_trig = pwdata[3:0];
        i2scf_pkg::RX_FLUSH_OFS:   rxf.flush = pwdata[0];
        i2scf_pkg::TX_FLUSH_OFS:   txf.flush = pwdata[0];
        i2scf_pkg::UNIT_CTRL_OFS: begin
          next_st.rx_en = pwdata[i2scf_pkg::CTRL_RX_EN];
          next_st.tx_en = pwdata[i2scf_pkg::CTRL_TX_EN];
        end
        i2scf_pkg::RX_DMA_PTR_RST_OFS: begin
          if (pwdata[0]) begin
            next_st.rx_dma_right = 1'b0;
          end
        end
        i2scf_pkg::LEFT_HOLD_OFS:  next_st.tx_left_hold = pwdata[15:0];
        i2scf_pkg::RIGHT_HOLD_OFS: begin
          txf.push  = 1'b1;
          txf.wdata = {pwdata[15:0], st.tx_left_hold};
          if (txf.full) begin
            next_st.tx_ovr = 1'b1;
          end
        end
        i2scf_pkg::TX_DMA_OFS: begin
          next_st.tx_dma_right = !st.tx_dma_right;
          if (!st.tx_dma_right) begin
            next_st.tx_left_hold = pwdata[15:0];
          end else begin
            txf.push  = 1'b1;
            txf.wdata = {pwdata[15:0], st.tx_left_hold};
            if (txf.full) begin
              next_st.tx_ovr = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end else if (access) begin
      case (paddr)
        // Clear only what was returned; a later set stays visible
        i2scf_pkg::RX_OVR_CLEAR_OFS: next_st.rx_ovr = st.rx_ovr && !st.prdata[0];
        i2scf_pkg::TX_OVR_CLEAR_OFS: next_st.tx_ovr = st.tx_ovr && !st.prdata[0];
        i2scf_pkg::RIGHT_HOLD_OFS:   rxf.pop = 1'b1;   // Right read retires the pair
        i2scf_pkg::RX_DMA_OFS: begin
          next_st.rx_dma_right = !st.rx_dma_right;
          rxf.pop              = st.rx_dma_right;
        end
        default: ;
      endcase
    end

    // Receiver: sample on rising edge, word ends where ws flips
    if (st.rx_en && sclk_rise) begin
      rx_word = {st.rx_sh[30:0], st.sd_s[1]};
      if (ws_now != st.ws_rx_last) begin
        if (rx_len != 6'h20) begin
          rx_word = rx_word & ((32'h1 << rx_len) - 32'h1);
        end
        next_st.ws_rx_last = ws_now;
        next_st.rx_sh      = 32'h0;
        if (!st.ws_rx_last) begin
          next_st.rx_left = rx_word[15:0];
        end else if (rxf.full) begin
          next_st.rx_ovr = 1'b1;
        end else begin
          rxf.push  = 1'b1;
          rxf.wdata = {rx_word[15:0], st.rx_left};
        end
      end else begin
        next_st.rx_sh = rx_word;
      end
    end

    // Transmitter: drive on falling edge, MSB first after ws flips
    if (st.tx_en && sclk_fall) begin
      if (ws_now != st.ws_tx_last) begin
        next_st.ws_tx_last = ws_now;
        if (!ws_now) begin
          // Empty FIFO sends silence rather than stale data
          txf.pop                = !txf.empty;
          tx_sample              = txf.empty ? 16'h0 : txf.rdata[15:0];
          next_st.tx_right_pend  = txf.empty ? 16'h0 : txf.rdata[31:16];
        end else begin
          tx_sample = st.tx_right_pend;
        end
        tx_word       = {16'h0, tx_sample} << (6'h20 - tx_len);
        next_st.sd_o  = tx_word[31];
        next_st.tx_sh = {tx_word[30:0], 1'b0};
      end else begin
        next_st.sd_o  = st.tx_sh[31];
        next_st.tx_sh = {st.tx_sh[30:0], 1'b0};
      end
    end else if (!st.tx_en) begin
      next_st.sd_o = 1'b0;
    end

    // Status view and interrupt; sets above already beat clears
    next_st.status                          = 6'h00;
    next_st.status[i2scf_pkg::ST_TX_OVR]    = next_st.tx_ovr;
    next_st.status[i2scf_pkg::ST_TX_EMPTY]  = (txf.level <= st.tx_trig);
    next_st.status[i2scf_pkg::ST_RX_OVR]    = next_st.rx_ovr;
    next_st.status[i2scf_pkg::ST_RX_READY]  = (rxf.level > st.rx_trig);
    next_st.irq = |(next_st.status & ~next_st.mask & i2scf_pkg::IRQ_BITS);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st         <= '0;
      st.rx_word_length_sel <= i2scf_pkg::WORD_LENGTH_SEL_RESET;
      st.tx_word_length_sel <= i2scf_pkg::WORD_LENGTH_SEL_RESET;
      st.mask    <= i2scf_pkg::MASK_RESET;
      st.status  <= i2scf_pkg::STATUS_RESET;
      st.rx_trig <= i2scf_pkg::TRIG_RESET;
      st.tx_trig <= i2scf_pkg::TRIG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign prdata   = st.prdata;
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign sclk_out = st.sclk_o;
  assign sclk_oe  = st.master;   // Slave end leaves the clock to the peer
  assign ws_out   = st.ws_o;
  assign ws_oe    = st.master;
  assign sd_out   = st.sd_o;
  assign irq      = st.irq;

endmodule : i2scf_channel_ctrl

// ### dv/i2scf_props.sv
// Port-level checker for the channel control block.
// Assumes one pclk domain and that config changes only by APB writes.
`timescale 1ns/1ns
module i2scf_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        peripheral_role_select,
  input wire logic        sclk_oe,
  input wire logic        irq
);
  // ----------------
  // Shadow registers
  // ----------------
  logic       wr;
  logic       rd;
  logic [2:0] cfg;
  logic [3:0] trg;
  logic [5:0] msk;
  logic [5:0] mskp;
  assign wr = psel && penable && pready && pwrite;
  assign rd = pready && !pwrite;
  // Same edge as the design's write; mskp covers the irq register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg  <= i2scf_pkg::WORD_LENGTH_SEL_RESET;
      trg  <= i2scf_pkg::TRIG_RESET;
      msk  <= i2scf_pkg::MASK_RESET;
      mskp <= i2scf_pkg::MASK_RESET;
    end else begin
      mskp <= msk;
      if (wr && paddr == i2scf_pkg::RX_CONFIG_OFS) cfg <= pwdata[2:0];
      if (wr && paddr == i2scf_pkg::RX_TRIGGER_OFS) trg <= pwdata[3:0];
      if (wr && paddr == i2scf_pkg::IRQ_MASK_OFS) msk <= pwdata[5:0] & i2scf_pkg::IRQ_BITS;
    end
  end

  // ----------
  // Properties
  // ----------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no zero-wait answer");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("pready held too long");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_oe; $past(presetn, 2) |-> sclk_oe == $past(peripheral_role_select); endproperty
  a_oe: assert property (p_oe) else $error("clock drive not by role");
  property p_cfg; rd && paddr == i2scf_pkg::RX_CONFIG_OFS |-> prdata == {29'h0, cfg}; endproperty
  a_cfg: assert property (p_cfg) else $error("rx word length read wrong");
  property p_trg; rd && paddr == i2scf_pkg::RX_TRIGGER_OFS |-> prdata == {28'h0, trg}; endproperty
  a_trg: assert property (p_trg) else $error("rx trigger read wrong");
  property p_msk; rd && paddr == i2scf_pkg::IRQ_MASK_OFS |-> prdata == {26'h0, msk}; endproperty
  a_msk: assert property (p_msk) else $error("mask read wrong");
  property p_stat;
    rd && paddr == i2scf_pkg::IRQ_STATUS_OFS |-> prdata[31:6] == 26'h0 && prdata[3:2] == 2'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status spare bits set");
  property p_quiet; msk == i2scf_pkg::MASK_RESET && mskp == i2scf_pkg::MASK_RESET |-> !irq; endproperty
  a_quiet: assert property (p_quiet) else $error("irq while all masked");
  c_ovr: cover property (rd && paddr == i2scf_pkg::IRQ_STATUS_OFS && prdata[5]);
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule : i2scf_props

bind i2scf_channel_ctrl i2scf_props u_props (.*);

// ### dv/i2scf_peer.sv
// I2S peer that plays one fixed stereo pair and records what it hears.
// Assumes the block is clock master; edges are found on pclk.
`timescale 1ns/1ns
module i2scf_peer (
  input  wire logic        pclk,
  input  wire logic        sclk,
  input  wire logic        ws,
  input  wire logic        sd_rx,
  input  wire logic [31:0] left_word,
  input  wire logic [31:0] right_word,
  output logic             sd,
  output logic [31:0]      heard_left,
  output logic [31:0]      heard_right
);
  // -------------
  // Serial engine
  // -------------
  logic        sp   = 1'b0;
  logic        wsf  = 1'b0;
  logic        wsr  = 1'b0;
  logic        pend = 1'b0;
  logic [31:0] sh   = 32'h0;
  logic [31:0] cap  = 32'h0;
  logic [31:0] word;
  assign word = ws ? right_word : left_word;
  initial sd = 1'b0;
  // Load one fall after ws flips, so the MSB lags ws by one bit
  always @(posedge pclk) begin
    sp <= sclk;
    if (sp && !sclk) begin
      wsf  <= ws;
      pend <= ws != wsf;
      sh   <= pend ? word << 1 : sh << 1;
      sd   <= pend ? word[31] : sh[31];
    end
    // All-zero words are idle slots and not kept
    if (!sp && sclk) begin
      wsr <= ws;
      cap <= {cap[30:0], sd_rx};
      if (ws != wsr && wsr && cap != 32'h0) heard_right <= {cap[30:0], sd_rx};
      if (ws != wsr && !wsr && cap != 32'h0) heard_left <= {cap[30:0], sd_rx};
    end
  end
endmodule : i2scf_peer

// ### dv/tb_i2s_channel_fifo_control.sv
// Self-checking bench for the channel control block.
// Assumes the peer model and the bound checker are compiled before it.
`timescale 1ns/1ns
module tb_i2s_channel_fifo_control;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        peripheral_role_select = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk_in;
  logic        sclk_out;
  logic        sclk_oe;
  logic        ws_in;
  logic        ws_out;
  logic        ws_oe;
  logic        sd_in;
  logic        sd_out;
  logic        irq;
  logic [31:0] q;
  logic        err;
  logic [31:0] heard_left;
  logic [31:0] heard_right;
  int          n_errors    = 0;
  int          check_count = 0;
  int          cycles      = 0;
  // ------------------
  // Pins, DUT and peer
  // ------------------
  // Undriven clock and select pins are pulled low
  assign sclk_in = sclk_oe ? sclk_out : 1'b0;
  assign ws_in   = ws_oe ? ws_out : 1'b0;
  i2scf_channel_ctrl DUT (.*);
  i2scf_peer PEER (
    .pclk        (pclk),
    .sclk        (sclk_in),
    .ws          (ws_in),
    .sd_rx       (sd_out),
    .left_word   (32'h1357A5C3),
    .right_word  (32'h24683C5A),
    .sd          (sd_in),
    .heard_left  (heard_left),
    .heard_right (heard_right)
  );
  always #4 pclk = ~pclk;
  // Hang guard, well above the roughly 9k cycles needed
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      wrap_up();
    end
  end
  // -----
  // Tasks
  // -----
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One APB transfer; the trailing edge keeps requests apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask : rchk
  task automatic t_reset;
    rchk(i2scf_pkg::TX_CONFIG_OFS, 32'h2, "tx_config");
    rchk(i2scf_pkg::IRQ_STATUS_OFS, 32'h10, "status");
    rchk(i2scf_pkg::IRQ_MASK_OFS, 32'h33, "mask");
    rchk(i2scf_pkg::RX_TRIGGER_OFS, 32'h3, "rx_trig");
    rchk(i2scf_pkg::TX_TRIGGER_OFS, 32'h3, "tx_trig");
    rchk(12'hFFC, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, err});
    // Slave role must let go of both link clocks
    peripheral_role_select <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("sclk_oe_slave", 32'h0, {31'h0, sclk_oe});
    chk("ws_oe_slave", 32'h0, {31'h0, ws_oe});
    peripheral_role_select <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("ws_oe_master", 32'h1, {31'h0, ws_oe});
    $display("test reset done");
  endtask : t_reset
  task automatic t_word_length_sel;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, i2scf_pkg::RX_CONFIG_OFS, 32'(i));
      apb(1'b1, i2scf_pkg::TX_CONFIG_OFS, 32'(i));
      rchk(i2scf_pkg::RX_CONFIG_OFS, 32'(i), "rx_config");
      rchk(i2scf_pkg::TX_CONFIG_OFS, 32'(i), "tx_config");
    end
    apb(1'b1, i2scf_pkg::RX_CONFIG_OFS, 32'h2);
    apb(1'b1, i2scf_pkg::TX_CONFIG_OFS, 32'h2);
    $display("test word_length_sel done");
  endtask : t_word_length_sel
  task automatic t_irq;
    apb(1'b1, i2scf_pkg::IRQ_MASK_OFS, 32'h23);
    @(posedge pclk);
    chk("irq_open", 32'h1, {31'h0, irq});
    apb(1'b1, i2scf_pkg::IRQ_MASK_OFS, 32'h33);
    @(posedge pclk);
    chk("irq_shut", 32'h0, {31'h0, irq});
    $display("test irq done");
  endtask : t_irq
  task automatic t_tx;
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, i2scf_pkg::LEFT_HOLD_OFS, 32'h1111);
      apb(1'b1, i2scf_pkg::RIGHT_HOLD_OFS, 32'h2222);
    end
    rchk(i2scf_pkg::IRQ_STATUS_OFS, 32'h20, "status_full");
    rchk(i2scf_pkg::TX_OVR_CLEAR_OFS, 32'h1, "tx_ovr");
    rchk(i2scf_pkg::TX_OVR_CLEAR_OFS, 32'h0, "tx_ovr_again");
    apb(1'b1, i2scf_pkg::TX_FLUSH_OFS, 32'h1);
    rchk(i2scf_pkg::IRQ_STATUS_OFS, 32'h10, "status_flushed");
    apb(1'b1, i2scf_pkg::TX_DMA_OFS, 32'h9A5C);
    apb(1'b1, i2scf_pkg::TX_DMA_OFS, 32'h36C1);
    apb(1'b1, i2scf_pkg::UNIT_CTRL_OFS, 32'h2);
    for (int i = 0; i < 3000 && heard_right !== 32'h36C10000; i++) @(posedge pclk);
    chk("heard_left", 32'h9A5C0000, heard_left);
    chk("heard_right", 32'h36C10000, heard_right);
    apb(1'b1, i2scf_pkg::UNIT_CTRL_OFS, 32'h0);
    $display("test tx done");
  endtask : t_tx
  task automatic t_rx;
    apb(1'b1, i2scf_pkg::RX_TRIGGER_OFS, 32'h1);
    apb(1'b1, i2scf_pkg::IRQ_MASK_OFS, 32'h32);
    apb(1'b1, i2scf_pkg::UNIT_CTRL_OFS, 32'h1);
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge pclk);
    rchk(i2scf_pkg::IRQ_STATUS_OFS, 32'h11, "status_ready");
    // First pair may start mid-word, so it is dropped unchecked
    apb(1'b0, i2scf_pkg::RIGHT_HOLD_OFS, 32'h0);
    rchk(i2scf_pkg::LEFT_HOLD_OFS, 32'hA5C3, "left_hold");
    rchk(i2scf_pkg::RX_DMA_OFS, 32'hA5C3, "dma_left");
    apb(1'b1, i2scf_pkg::RX_DMA_PTR_RST_OFS, 32'h1);
    rchk(i2scf_pkg::RX_DMA_OFS, 32'hA5C3, "dma_restart");
    rchk(i2scf_pkg::RX_DMA_OFS, 32'h3C5A, "dma_right");
    apb(1'b1, i2scf_pkg::IRQ_MASK_OFS, 32'h31);
    for (int i = 0; i < 9000 && irq !== 1'b1; i++) @(posedge pclk);
    chk("irq_rx_ovr", 32'h1, {31'h0, irq});
    apb(1'b1, i2scf_pkg::UNIT_CTRL_OFS, 32'h0);
    rchk(i2scf_pkg::RX_OVR_CLEAR_OFS, 32'h1, "rx_ovr");
    rchk(i2scf_pkg::RX_OVR_CLEAR_OFS, 32'h0, "rx_ovr_again");
    apb(1'b1, i2scf_pkg::RX_FLUSH_OFS, 32'h1);
    rchk(i2scf_pkg::IRQ_STATUS_OFS, 32'h10, "status_rx_flushed");
    $display("test rx done");
  endtask : t_rx
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_word_length_sel();
    t_irq();
    t_tx();
    t_rx();
    wrap_up();
  end
endmodule : tb_i2s_channel_fifo_control
